// ---- hdl/rxdq_defines.svh ----
`ifndef RXDQ_DEFINES_SVH
`define RXDQ_DEFINES_SVH

// Register byte addresses.
`define RXDQ_ADDR_GLB_CTRL   12'h700
`define RXDQ_ADDR_STATUS     12'h704
`define RXDQ_ADDR_IRQ_EN     12'h708
`define RXDQ_ADDR_STATE      12'h70C
`define RXDQ_ADDR_BASE_LO    12'h730
`define RXDQ_ADDR_BASE_HI    12'h734
`define RXDQ_ADDR_END_IDX    12'h738
`define RXDQ_ADDR_RD_PTR     12'h73C
`define RXDQ_ADDR_WR_PTR     12'h740
`define RXDQ_ADDR_FFT        12'h744
`define RXDQ_ADDR_QCTRL      12'h780

// Field positions.
`define RXDQ_GLB_RX_EN       0
`define RXDQ_CTL_BURST_EN    4
`define RXDQ_CTL_FLUSH       5
`define RXDQ_CTL_THR_LSB     8
`define RXDQ_CTL_MASK        16'h073D
`define RXDQ_STAT_WRITE      0
`define RXDQ_STAT_ERROR      1
`define RXDQ_DESC_EOF        30
`define RXDQ_DESC_CNT_LSB    24

// Reset values.
`define RXDQ_RST_HALF        16'h0000
`define RXDQ_RST_WORD        32'h0000_0000

// Timing and sizes.
`define RXDQ_TICK_DIV        256
`define RXDQ_FIFO_DEPTH      8
`define RXDQ_HIGH_WATER      6

// AXI responses.
`define RXDQ_RESP_OKAY       2'h0
`define RXDQ_RESP_SLVERR     2'h2

`endif

// ---- hdl/rxdq_pkg.sv ----
`include "rxdq_defines.svh"

package rxdq_pkg;

   typedef enum logic [1:0] {
      RXDQ_IDLE  = 2'b00,
      RXDQ_BURST = 2'b01
   } rxdq_state_e;

   typedef logic [`RXDQ_FIFO_DEPTH-1:0][31:0] rxdq_fifo_t;

   typedef struct packed {
      rxdq_state_e  state;
      logic [15:0]  base_lo;
      logic [15:0]  base_hi;
      logic [15:0]  end_idx;
      logic [15:0]  rd_ptr;
      logic [15:0]  wr_ptr;
      logic [15:0]  fft_reload;
      logic [15:0]  qctrl;
      logic         rx_en;
      logic [1:0]   status;
      logic [1:0]   irq_en;
      logic         irq;
      logic [15:0]  timer;
      logic [7:0]   presc;
      logic [7:0]   stat_cnt;
      rxdq_fifo_t   fifo;
      logic [2:0]   head;
      logic [2:0]   tail;
      logic [3:0]   count;
      logic [3:0]   rem;
      logic         mem_valid;
      logic [31:0]  mem_addr;
      logic [31:0]  mem_data;
      logic         mem_last;
      logic         desc_ready;
      logic         aw_got;
      logic         w_got;
      logic [11:0]  aw_addr;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic         awready;
      logic         wready;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         arready;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
   } rxdq_regs_s;

endpackage : rxdq_pkg

// ---- hdl/rxdq_writer.sv ----
`timescale 1ns/10ps
`include "rxdq_defines.svh"
// Functional notes
// - Write address is done-queue base plus write pointer times 4, full 32 bits.
// - No done-queue write until the global receive DMA enable is set.
// - Each descriptor written advances the write pointer by one dword.
// - Pointer passing the end index reloads zero, back to base.
// - End register is a dword index; absolute end is base plus index times 4.
// - Queue base is held as a low word and a high word register.
// - Full queue raises write error; no write and no pointer advance.
// - Write flag set after 1, 2, 4 ... 128 writes per 3-bit code.
// - Each status flag can drive the interrupt when its enable is set.
// - Per-channel threshold posts after 1..7 buffers, or at packet end.
// - Packet end always posts, even below the buffer threshold.
// - Internal burst FIFO holds up to eight one-dword descriptors.
// - Burst enable 0 writes singly; 1 buffers descriptors in the FIFO.
// - With bursting, wait for six buffered descriptors, then burst write.
// - Burst only as many descriptors as free queue space allows.
// - No space for any buffered descriptor raises error, writes nothing.
// - Successful burst advances pointer by the number of descriptors written and counts its writes toward the write flag.
// - 16-bit flush timer decrements every 256 clocks while bursting.
// - The last write of each queue burst reloads the timer from the host value.
// - While force flush is held, all buffered descriptors are pushed out.
// - Device and host both update write pointer; host alone updates read pointer.
// - Equal read and write pointers mean the queue is empty.
// - Read pointer one ahead of write pointer means the queue is full.

module rxdq_writer #(
   parameter int HIGH_WATER = `RXDQ_HIGH_WATER
) (
   input  wire logic        CLK_SYS,
   input  wire logic        ARST_N,
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output      logic        S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output      logic        S_AXI_WREADY,
   output      logic [1:0]  S_AXI_BRESP,
   output      logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output      logic        S_AXI_ARREADY,
   output      logic [31:0] S_AXI_RDATA,
   output      logic [1:0]  S_AXI_RRESP,
   output      logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic [31:0] DESC_WORD,
   input  wire logic [2:0]  DESC_THRESH,
   input  wire logic        DESC_VALID,
   output      logic        DESC_READY,
   output      logic        DQ_WR_VALID,
   output      logic [31:0] DQ_WR_ADDR,
   output      logic [31:0] DQ_WR_DATA,
   output      logic        DQ_WR_LAST,
   input  wire logic        DQ_WR_READY,
   output      logic        IRQ
);

   // ***********************************************************
   // Helpers
   // ***********************************************************
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  strb);
      logic [15:0] m;
      m = {{8{strb[1]}}, {8{strb[0]}}};
      return (old_v & ~m) | (new_v[15:0] & m);
   endfunction : merge16

   function automatic logic [31:0] slot_addr(input logic [15:0] lo,
                                             input logic [15:0] hi,
                                             input logic [15:0] ptr);
      return {hi, lo} + {14'h0000, ptr, 2'b00};
   endfunction : slot_addr

   // ***********************************************************
   // State
   // ***********************************************************
   rxdq_pkg::rxdq_regs_s s_q;
   rxdq_pkg::rxdq_regs_s s_d;

   logic        host_wr;
   logic [11:0] wa;
   logic [11:0] ra;
   logic        hit;
   logic        push;
   logic        post;
   logic        pop;
   logic        drop_all;
   logic        burst_en;
   logic        trigger;
   logic        tick;
   logic [16:0] qsize;
   logic [16:0] free;
   logic [3:0]  n;
   logic [15:0] wr_nxt;
   logic [7:0]  cnt_nx;
   logic [7:0]  target;
   logic [2:0]  head_nx;

   always_comb begin
      s_d      = s_q;
      pop      = 1'b0;
      drop_all = 1'b0;
      free     = 17'h0_0000;
      n        = 4'h0;
      cnt_nx   = 8'h00;
      head_nx  = s_q.head;
      hit      = 1'b1;
      burst_en = s_q.qctrl[`RXDQ_CTL_BURST_EN];

      // ********************************************************
      // AXI4-Lite write channel
      // ********************************************************
      if (S_AXI_AWVALID && s_q.awready) begin
         s_d.aw_got  = 1'b1;
         s_d.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && s_q.wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = S_AXI_WDATA;
         s_d.wstrb = S_AXI_WSTRB;
      end
      if (s_q.bvalid && S_AXI_BREADY) begin
         s_d.bvalid = 1'b0;
      end
      host_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
      wa      = {s_q.aw_addr[11:2], 2'b00};
      if (host_wr) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         case (wa)
            `RXDQ_ADDR_GLB_CTRL: begin
               if (s_q.wstrb[0]) begin
                  s_d.rx_en = s_q.wdata[`RXDQ_GLB_RX_EN];
               end
            end
            `RXDQ_ADDR_STATUS: begin
               if (s_q.wstrb[0]) begin
                  s_d.status = s_q.status & ~s_q.wdata[1:0];
               end
            end
            `RXDQ_ADDR_IRQ_EN: begin
               if (s_q.wstrb[0]) begin
                  s_d.irq_en = s_q.wdata[1:0];
               end
            end
            `RXDQ_ADDR_STATE: begin
            end
            `RXDQ_ADDR_BASE_LO: begin
               s_d.base_lo = merge16(s_q.base_lo, s_q.wdata, s_q.wstrb);
            end
            `RXDQ_ADDR_BASE_HI: begin
               s_d.base_hi = merge16(s_q.base_hi, s_q.wdata, s_q.wstrb);
            end
            `RXDQ_ADDR_END_IDX: begin
               s_d.end_idx = merge16(s_q.end_idx, s_q.wdata, s_q.wstrb);
            end
            `RXDQ_ADDR_RD_PTR: begin
               s_d.rd_ptr = merge16(s_q.rd_ptr, s_q.wdata, s_q.wstrb);
            end
            `RXDQ_ADDR_WR_PTR: begin
               s_d.wr_ptr = merge16(s_q.wr_ptr, s_q.wdata, s_q.wstrb);
            end
            `RXDQ_ADDR_FFT: begin
               s_d.fft_reload = merge16(s_q.fft_reload, s_q.wdata,
                                        s_q.wstrb);
            end
            `RXDQ_ADDR_QCTRL: begin
               s_d.qctrl = merge16(s_q.qctrl, s_q.wdata, s_q.wstrb)
                           & `RXDQ_CTL_MASK;
            end
            default: begin
               hit = 1'b0;
            end
         endcase
         s_d.bresp = hit ? `RXDQ_RESP_OKAY : `RXDQ_RESP_SLVERR;
      end
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready  = !s_d.w_got && !s_d.bvalid;

      // ********************************************************
      // AXI4-Lite read channel
      // ********************************************************
      if (s_q.rvalid && S_AXI_RREADY) begin
         s_d.rvalid = 1'b0;
      end
      ra = {S_AXI_ARADDR[11:2], 2'b00};
      if (S_AXI_ARVALID && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = `RXDQ_RESP_OKAY;
         case (ra)
            `RXDQ_ADDR_GLB_CTRL: s_d.rdata = {31'h0000_0000, s_q.rx_en};
            `RXDQ_ADDR_STATUS:   s_d.rdata = {30'h0000_0000, s_q.status};
            `RXDQ_ADDR_IRQ_EN:   s_d.rdata = {30'h0000_0000, s_q.irq_en};
            `RXDQ_ADDR_STATE:    s_d.rdata = {s_q.timer, 12'h000, s_q.count};
            `RXDQ_ADDR_BASE_LO:  s_d.rdata = {16'h0000, s_q.base_lo};
            `RXDQ_ADDR_BASE_HI:  s_d.rdata = {16'h0000, s_q.base_hi};
            `RXDQ_ADDR_END_IDX:  s_d.rdata = {16'h0000, s_q.end_idx};
            `RXDQ_ADDR_RD_PTR:   s_d.rdata = {16'h0000, s_q.rd_ptr};
            `RXDQ_ADDR_WR_PTR:   s_d.rdata = {16'h0000, s_q.wr_ptr};
            `RXDQ_ADDR_FFT:      s_d.rdata = {16'h0000, s_q.fft_reload};
            `RXDQ_ADDR_QCTRL:    s_d.rdata = {16'h0000, s_q.qctrl};
            default: begin
               s_d.rdata = `RXDQ_RST_WORD;
               s_d.rresp = `RXDQ_RESP_SLVERR;
            end
         endcase
      end
      s_d.arready = !s_d.rvalid;

      // ********************************************************
      // Descriptor intake
      // ********************************************************
      // Descriptors below the channel threshold are consumed but not
      // posted; the channel logic only offers one at each buffer fill.
      post = DESC_WORD[`RXDQ_DESC_EOF] ||
             (DESC_THRESH != 3'b000 &&
              DESC_WORD[`RXDQ_DESC_CNT_LSB +: 3] >= DESC_THRESH);
      push = DESC_VALID && s_q.desc_ready && post;
      if (push) begin
         s_d.fifo[s_q.tail] = DESC_WORD;
      end

      // ********************************************************
      // Flush timer
      // ********************************************************
      tick = (s_q.presc == 8'(`RXDQ_TICK_DIV - 1));
      s_d.presc = s_q.presc + 8'h01;
      if (burst_en && tick && s_q.timer != 16'h0000) begin
         s_d.timer = s_q.timer - 16'h0001;
      end

      // ********************************************************
      // Queue space and write engine
      // ********************************************************
      qsize = {1'b0, s_q.end_idx} + 17'h0_0001;
      if (s_q.rd_ptr > s_q.wr_ptr) begin
         free = {1'b0, s_q.rd_ptr} - {1'b0, s_q.wr_ptr} - 17'h0_0001;
      end else begin
         // Equal pointers leave qsize-1 free; one slot stays empty.
         free = qsize - {1'b0, s_q.wr_ptr} + {1'b0, s_q.rd_ptr}
                - 17'h0_0001;
      end
      if (!burst_en) begin
         n = (free != 17'h0_0000) ? 4'h1 : 4'h0;
      end else if (free < {13'h0000, s_q.count}) begin
         n = free[3:0];
      end else begin
         n = s_q.count;
      end
      wr_nxt = (s_q.wr_ptr == s_q.end_idx) ? 16'h0000
                                           : s_q.wr_ptr + 16'h0001;
      if (!burst_en) begin
         trigger = s_q.count != 4'h0;
      end else begin
         trigger = s_q.count >= 4'(HIGH_WATER) ||
                   (s_q.qctrl[`RXDQ_CTL_FLUSH] &&
                    s_q.count != 4'h0) ||
                   (s_q.timer == 16'h0000 && s_q.count != 4'h0);
      end
      target = 8'h01 << s_q.qctrl[`RXDQ_CTL_THR_LSB +: 3];

      case (s_q.state)
         rxdq_pkg::RXDQ_IDLE: begin
            if (trigger && s_q.rx_en) begin
               if (n == 4'h0) begin
                  s_d.status[`RXDQ_STAT_ERROR] = 1'b1;
                  // The refused descriptors are lost, as on the host side.
                  drop_all = burst_en;
                  pop      = !burst_en;
               end else begin
                  s_d.state     = rxdq_pkg::RXDQ_BURST;
                  s_d.rem       = n;
                  s_d.mem_valid = 1'b1;
                  s_d.mem_addr  = slot_addr(s_q.base_lo, s_q.base_hi,
                                            s_q.wr_ptr);
                  s_d.mem_data  = s_q.fifo[s_q.head];
                  s_d.mem_last  = (n == 4'h1);
               end
            end
         end
         rxdq_pkg::RXDQ_BURST: begin
            if (s_q.mem_valid && DQ_WR_READY) begin
               pop        = 1'b1;
               head_nx    = s_q.head + 3'h1;
               s_d.wr_ptr = wr_nxt;
               s_d.rem    = s_q.rem - 4'h1;
               cnt_nx     = s_q.stat_cnt + 8'h01;
               if (cnt_nx >= target) begin
                  s_d.status[`RXDQ_STAT_WRITE] = 1'b1;
                  s_d.stat_cnt = 8'h00;
               end else begin
                  s_d.stat_cnt = cnt_nx;
               end
               if (s_q.rem == 4'h1) begin
                  s_d.state     = rxdq_pkg::RXDQ_IDLE;
                  s_d.mem_valid = 1'b0;
                  s_d.mem_last  = 1'b0;
                  s_d.timer     = s_q.fft_reload;
               end else begin
                  s_d.mem_addr = slot_addr(s_q.base_lo, s_q.base_hi,
                                           wr_nxt);
                  s_d.mem_data = s_q.fifo[head_nx];
                  s_d.mem_last = (s_q.rem == 4'h2);
               end
            end
         end
         default: begin
            s_d.state     = rxdq_pkg::RXDQ_IDLE;
            s_d.mem_valid = 1'b0;
         end
      endcase

      // ********************************************************
      // FIFO bookkeeping
      // ********************************************************
      s_d.tail = s_q.tail + {2'b00, push};
      if (drop_all) begin
         s_d.head  = s_q.tail;
         s_d.count = {3'b000, push};
      end else begin
         s_d.head  = s_q.head + {2'b00, pop};
         s_d.count = s_q.count + {3'b000, push} - {3'b000, pop};
      end
      s_d.desc_ready = s_d.rx_en &&
                       s_d.count < 4'(`RXDQ_FIFO_DEPTH);
      s_d.irq = |(s_d.status & s_d.irq_en);
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         s_q            <= '0;
         s_q.state      <= rxdq_pkg::RXDQ_IDLE;
         s_q.fft_reload <= `RXDQ_RST_HALF;
         s_q.qctrl      <= `RXDQ_RST_HALF;
         s_q.timer      <= `RXDQ_RST_HALF;
         s_q.bresp      <= `RXDQ_RESP_OKAY;
         s_q.rresp      <= `RXDQ_RESP_OKAY;
      end else begin
         s_q <= s_d;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign S_AXI_AWREADY = s_q.awready;
   assign S_AXI_WREADY  = s_q.wready;
   assign S_AXI_BVALID  = s_q.bvalid;
   assign S_AXI_BRESP   = s_q.bresp;
   assign S_AXI_ARREADY = s_q.arready;
   assign S_AXI_RVALID  = s_q.rvalid;
   assign S_AXI_RDATA   = s_q.rdata;
   assign S_AXI_RRESP   = s_q.rresp;
   assign DESC_READY    = s_q.desc_ready;
   assign DQ_WR_VALID   = s_q.mem_valid;
   assign DQ_WR_ADDR    = s_q.mem_addr;
   assign DQ_WR_DATA    = s_q.mem_data;
   assign DQ_WR_LAST    = s_q.mem_last;
   assign IRQ           = s_q.irq;

endmodule : rxdq_writer

// ---- tb/rxdq_monitor.sv ----
`timescale 1ns/10ps
// ********************************************************************
// Port-level checks on the register bus and the done-queue writes.
// ********************************************************************
module rxdq_monitor (
   input logic        CLK_SYS,
   input logic        ARST_N,
   input logic        S_AXI_AWVALID,
   input logic        S_AXI_AWREADY,
   input logic        S_AXI_WVALID,
   input logic        S_AXI_WREADY,
   input logic        S_AXI_BVALID,
   input logic        S_AXI_ARVALID,
   input logic        S_AXI_ARREADY,
   input logic        S_AXI_RVALID,
   input logic        DQ_WR_VALID,
   input logic [31:0] DQ_WR_ADDR,
   input logic [31:0] DQ_WR_DATA,
   input logic        DQ_WR_LAST,
   input logic        DQ_WR_READY
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);

   a_dq_hold: assert property (
      DQ_WR_VALID && !DQ_WR_READY |=> DQ_WR_VALID
      && $stable(DQ_WR_ADDR) && $stable(DQ_WR_DATA))
      else $error("done write changed before it was taken");
   a_burst_run: assert property (
      DQ_WR_VALID && DQ_WR_READY && !DQ_WR_LAST |=> DQ_WR_VALID)
      else $error("burst stopped before its last word");
   a_burst_gap: assert property (
      DQ_WR_VALID && DQ_WR_READY && DQ_WR_LAST |=> !DQ_WR_VALID)
      else $error("no idle cycle after the last word");
   a_addr_step: assert property (
      DQ_WR_VALID && DQ_WR_READY && !DQ_WR_LAST
      |=> DQ_WR_ADDR != $past(DQ_WR_ADDR))
      else $error("burst word reused the same address");
   a_b_answer: assert property (
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##[1:2] S_AXI_BVALID)
      else $error("write response late");
   a_r_answer: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID)
      else $error("read data late");
   a_r_busy: assert property (
      S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read address taken while data pending");
   a_w_busy: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while response pending");

   c_burst: cover property (DQ_WR_VALID && !DQ_WR_LAST ##1 DQ_WR_LAST);
   c_bresp: cover property (S_AXI_BVALID);
   c_rdata: cover property (S_AXI_RVALID);
endmodule : rxdq_monitor

bind rxdq_writer rxdq_monitor mon_u (.*);

// ---- tb/rxdq_host_mem.sv ----
`timescale 1ns/10ps
// ********************************************************************
// Host memory behind the done-queue write port.
// ********************************************************************
module rxdq_host_mem (
   input  logic        CLK_SYS,
   input  logic        ARST_N,
   input  logic        DQ_WR_VALID,
   input  logic [31:0] DQ_WR_ADDR,
   input  logic [31:0] DQ_WR_DATA,
   input  logic        DQ_WR_LAST,
   input  logic        slow,
   output logic        DQ_WR_READY,
   output logic [15:0] nwords,
   output logic [15:0] nbursts,
   output logic [31:0] last_addr,
   output logic [31:0] last_data
);
   // Slow mode stalls every other cycle so bursts see back-pressure.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         DQ_WR_READY <= 1'b0;
         nwords      <= 16'h0000;
         nbursts     <= 16'h0000;
      end else begin
         DQ_WR_READY <= slow ? ~DQ_WR_READY : 1'b1;
         if (DQ_WR_VALID && DQ_WR_READY) begin
            nwords    <= nwords + 16'h0001;
            last_addr <= DQ_WR_ADDR;
            last_data <= DQ_WR_DATA;
            if (DQ_WR_LAST)
               nbursts <= nbursts + 16'h0001;
         end
      end
   end
endmodule : rxdq_host_mem

// ---- tb/rxdq_writer_tb.sv ----
`timescale 1ns/10ps
`include "rxdq_defines.svh"
// ********************************************************************
// Register and descriptor traffic against the done-queue writer.
// ********************************************************************
module rxdq_writer_tb;
   localparam logic [31:0] BASE = 32'hA5C1_0040;
   logic        CLK_SYS, ARST_N, slow, IRQ;
   logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, DESC_WORD, DQ_WR_ADDR;
   logic [31:0] DQ_WR_DATA, last_addr, last_data, rd_d;
   logic [3:0]  S_AXI_WSTRB;
   logic [2:0]  DESC_THRESH;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rd_r, wr_r;
   logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
   logic        S_AXI_RVALID, S_AXI_RREADY, DESC_VALID, DESC_READY;
   logic        DQ_WR_VALID, DQ_WR_LAST, DQ_WR_READY;
   logic [15:0] nwords, nbursts;
   int          failures, n_tests, wrp, endv, k, j;

   rxdq_writer   dut_u (.*);
   rxdq_host_mem mem_u (.*);

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      S_AXI_AWADDR  <= a;
      S_AXI_WDATA   <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID  <= 1'b1;
      do begin
         @(posedge CLK_SYS);
         if (S_AXI_AWREADY)
            S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY)
            S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1);
      wr_r = S_AXI_BRESP;
   endtask : axw

   task automatic axr(input logic [11:0] a);
      S_AXI_ARADDR  <= a;
      S_AXI_ARVALID <= 1'b1;
      do begin
         @(posedge CLK_SYS);
         if (S_AXI_ARREADY)
            S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1);
      rd_d = S_AXI_RDATA;
      rd_r = S_AXI_RRESP;
   endtask : axr

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      axr(a);
      chk(rd_d, e);
   endtask : rdc

   // Offers one descriptor, then expects exactly w words in memory.
   task automatic post(input logic [31:0] d, input int t, input int w);
      int n;
      logic [15:0] c0;
      n = 0;
      c0 = nwords;
      DESC_WORD   <= d;
      DESC_THRESH <= t[2:0];
      DESC_VALID  <= 1'b1;
      do @(posedge CLK_SYS); while (DESC_READY !== 1'b1);
      DESC_VALID <= 1'b0;
      n = 0;
      while (n < 30 && !(w > 0 && nwords == c0 + w)) begin
         @(posedge CLK_SYS);
         n++;
      end
      chk(nwords - c0, w);
      if (w > 0)
         chk(last_addr, BASE + 4 * ((wrp + w - 1) % (endv + 1)));
      wrp = (wrp + w) % (endv + 1);
   endtask : post

   task automatic wrap_up();
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   initial begin
      CLK_SYS = 1'b0;
      forever #50 CLK_SYS = ~CLK_SYS;
   end

   initial begin
      repeat (40000) @(posedge CLK_SYS);
      failures++;
      wrap_up();
   end

   initial begin
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, DESC_VALID} = '0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, DESC_WORD} = '0;
      {DESC_THRESH, slow, ARST_N} = '0;
      {S_AXI_BREADY, S_AXI_RREADY, S_AXI_WSTRB} = 6'h3F;
      {failures, n_tests, wrp} = '0;
      endv = 255;
      repeat (5) @(posedge CLK_SYS);
      ARST_N <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      rdc(`RXDQ_ADDR_FFT, 0);
      rdc(`RXDQ_ADDR_QCTRL, 0);
      axr(12'h7F0);
      chk(rd_r, `RXDQ_RESP_SLVERR);
      axw(12'h7F0, 32'h0000_0001);
      chk(wr_r, `RXDQ_RESP_SLVERR);
      chk(DESC_READY, 0);
      axw(`RXDQ_ADDR_BASE_LO, 32'h0040);
      axw(`RXDQ_ADDR_BASE_HI, 32'hA5C1);
      axw(`RXDQ_ADDR_END_IDX, 255);
      axw(`RXDQ_ADDR_IRQ_EN, 1);
      axw(`RXDQ_ADDR_GLB_CTRL, 1);
      rdc(`RXDQ_ADDR_BASE_HI, 32'hA5C1);
      for (k = 0; k < 8; k++) begin
         axw(`RXDQ_ADDR_QCTRL, k << 8);
         axw(`RXDQ_ADDR_STATUS, 3);
         for (j = 1; j < (1 << k); j++)
            post(32'h4000_0000 | j, 0, 1);
         rdc(`RXDQ_ADDR_STATUS, 0);
         post(32'h4000_0000, 0, 1);
         rdc(`RXDQ_ADDR_STATUS, 1);
         chk(IRQ, 1);
      end
      axw(`RXDQ_ADDR_IRQ_EN, 0);
      repeat (2) @(posedge CLK_SYS);
      chk(IRQ, 0);
      axw(`RXDQ_ADDR_RD_PTR, wrp);
      axw(`RXDQ_ADDR_QCTRL, 0);
      // Single writes reload the timer, so the count is loaded before
      // them and holds a legal value when bursting is switched on.
      axw(`RXDQ_ADDR_FFT, 2);
      for (k = 1; k < 8; k++) begin
         post(k << 24, k, 1);
         post((k - 1) << 24, k, 0);
      end
      post(32'h0000_0000, 0, 0);
      post(32'h4100_0000, 5, 1);
      axw(`RXDQ_ADDR_QCTRL, 16'h0010);
      axw(`RXDQ_ADDR_STATUS, 3);
      slow <= 1'b1;
      j = nbursts;
      for (k = 0; k < 5; k++)
         post(32'h4000_0000 | k, 0, 0);
      post(32'h4000_0005, 0, 6);
      chk(nbursts, j + 1);
      chk(last_data, 32'h4000_0005);
      rdc(`RXDQ_ADDR_STATUS, 1);
      j = nwords;
      post(32'h4000_0010, 0, 0);
      post(32'h4000_0011, 0, 0);
      for (k = 0; k < 700 && nwords != j + 2; k++)
         @(posedge CLK_SYS);
      chk(nwords, j + 2);
      j = nwords + 1;
      post(32'h4000_0020, 0, 0);
      axw(`RXDQ_ADDR_QCTRL, 16'h0030);
      for (k = 0; k < 30 && nwords != j; k++)
         @(posedge CLK_SYS);
      chk(nwords, j);
      axw(`RXDQ_ADDR_QCTRL, 16'h0010);
      wrp = (wrp + 3) % 256;
      axw(`RXDQ_ADDR_RD_PTR, (wrp + 4) % 256);
      slow <= 1'b0;
      for (k = 0; k < 5; k++)
         post(32'h4000_0030 | k, 0, 0);
      post(32'h4000_0035, 0, 3);
      axw(`RXDQ_ADDR_STATUS, 3);
      j = nwords;
      // Two timer ticks of 256 clocks plus margin.
      repeat (700) @(posedge CLK_SYS);
      rdc(`RXDQ_ADDR_STATUS, 2);
      chk(nwords, j);
      rdc(`RXDQ_ADDR_WR_PTR, wrp);
      axw(`RXDQ_ADDR_QCTRL, 0);
      axw(`RXDQ_ADDR_END_IDX, 3);
      axw(`RXDQ_ADDR_WR_PTR, 0);
      axw(`RXDQ_ADDR_RD_PTR, 0);
      {wrp, endv} = {32'd0, 32'd3};
      for (k = 0; k < 3; k++)
         post(32'h4000_0040 | k, 0, 1);
      axw(`RXDQ_ADDR_STATUS, 3);
      post(32'h4000_0043, 0, 0);
      rdc(`RXDQ_ADDR_STATUS, 2);
      rdc(`RXDQ_ADDR_WR_PTR, 3);
      axw(`RXDQ_ADDR_RD_PTR, 3);
      post(32'h4000_0044, 0, 1);
      rdc(`RXDQ_ADDR_WR_PTR, 0);
      wrap_up();
   end
endmodule : rxdq_writer_tb
